// ---- rtl/timer_regs.svh ----
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// ------------------------------------------------------------
// register offsets (4-bit word address)
// ------------------------------------------------------------
`define OFF_CONTROL_A      4'h0
`define OFF_CONTROL_B      4'h1
`define OFF_CONTROL_E      4'h2
`define OFF_CONTROL_F      4'h3
`define OFF_COUNT          4'h4
`define OFF_CYCLE_LENGTH   4'h5
`define OFF_CYCLE_BUFFER   4'h6
`define OFF_STATUS         4'h7
`define OFF_MATCH_BASE     4'h8
`define OFF_MATCH_BUF_BASE 4'hC

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BIT_ENABLE         0
`define BIT_PRESCALE_LO    1
`define BIT_PRESCALE_HI    3
`define BIT_WAVE_LO        0
`define BIT_WAVE_HI        1
`define BIT_CH_EN_LO       4
`define BIT_CH_EN_HI       6
`define BIT_COUNT_SENSE    0
`define BIT_LOCK_TRANSFER  1
`define BIT_CYCLE_VALID    0
`define BIT_MATCH_VALID_LO 1
`define BIT_MATCH_VALID_HI 3
`define BIT_WRAP_FLAG      3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_COUNT          16'h0000
`define RST_CYCLE_LENGTH   16'hFFFF
`define RST_MATCH          16'h0000
`define ZERO_POINT         16'h0000

`endif

// ---- rtl/timer_pkg.sv ----
package timer_pkg;

   // ------------------------------------------------------------
   // register bus request
   // ------------------------------------------------------------
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_s;

   // ------------------------------------------------------------
   // waveform modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      WAVE_NORMAL = 2'b00,
      WAVE_TONE   = 2'b01,
      WAVE_SINGLE = 2'b11
   } wave_mode_e;

   typedef logic [15:0] word_t;

endpackage

// ---- rtl/timer_prescaler.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "timer_regs.svh"

module timer_prescaler (
   input  wire logic       clk_in,
   input  wire logic       arst_n_in,
   input  wire logic       run_in,
   input  wire logic [2:0] select_in,
   output logic            tick_out
);
   import timer_pkg::*;

   logic [9:0] div_cnt_reg;

   // ------------------------------------------------------------
   // divisor table: 1,2,4,8,16,64,256,1024
   // ------------------------------------------------------------
   function automatic logic [9:0] div_mask(input logic [2:0] sel);
      case (sel)
         3'd0:    div_mask = 10'h000;
         3'd1:    div_mask = 10'h001;
         3'd2:    div_mask = 10'h003;
         3'd3:    div_mask = 10'h007;
         3'd4:    div_mask = 10'h00F;
         3'd5:    div_mask = 10'h03F;
         3'd6:    div_mask = 10'h0FF;
         default: div_mask = 10'h3FF;
      endcase
   endfunction

   // free counter; wraps at 1024 so every mask divides evenly
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         div_cnt_reg <= 10'h000;
      end else if (run_in) begin
         div_cnt_reg <= div_cnt_reg + 10'h001;
      end else begin
         div_cnt_reg <= 10'h000;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tick_out <= 1'b0;
      end else begin
         tick_out <= run_in && ((div_cnt_reg & div_mask(select_in)) == div_mask(select_in)); // [R25]
      end
   end

endmodule // timer_prescaler

`default_nettype wire

// ---- rtl/timer_compare_waveform.sv ----
// Summary of operation
// [R1] counter steps once per prescaled tick, direction from count sense bit, changeable live
// [R2] counting up, count equal to upper limit returns to zero next tick
// [R3] counting down, at zero point the period value is loaded
// [R4] software count write is immediate and beats every count action
// [R5] period and three match values each own a pending buffer register
// [R6] buffer valid flag sets on buffer write, clears on transfer condition
// [R7] match value and its buffer both writable; direct write bypasses buffering
// [R8] direct period write applies immediately
// [R9] unbuffered up count compares continuously; lower period wraps through maximum first
// [R10] pending period buffer copied only at the transfer condition
// [R11] count equal match value sets channel flag on following clock
// [R12] pending match buffer copied at transfer, compared from next count
// [R13] pin driven only with wave mode, channel enable and pin direction output
// [R14] tone mode uses channel 0 match value as period
// [R15] tone mode toggles each channel output on its compare match
// [R16] tone frequency is clock over 2N(match0+1); max half clock
// [R17] channels 1 and 2 give same frequency, phase from match, count, direction
// [R18] single slope counts zero point to upper limit; set at zero, clear on match
// [R19] match at zero holds low; match above upper limit holds high
// [R20] software must not count down in single slope mode
// [R21] pwm resolution follows period, 2 to 16 bits
// [R22] single slope frequency is clock over N(period+1)
// [R23] transfer at zero point or upper limit; skipped while lock bit set
// [R24] zero point means count value 0x0000
// [R25] prescale select chooses the module clock divisor
// [R26] tone mode restarts count after reaching channel 0 match value
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "timer_regs.svh"

module timer_compare_waveform (
   input  wire logic               clk_in,
   input  wire logic               arst_n_in,
   input  wire timer_pkg::reg_req_s bus_req_in,
   input  wire logic [2:0]         pin_dir_in,
   output logic [15:0]             rd_data_out,
   output logic [2:0]              wave_pin_out,
   output logic [2:0]              wave_pin_oe_out
);
   import timer_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic        enable_reg;
   logic [2:0]  prescale_select_reg;
   wave_mode_e  wave_shape_select_reg;
   logic [2:0]  channel_output_enable_reg;
   logic        count_sense_reg;
   logic        lock_transfer_reg;
   word_t       count_value_reg;
   word_t       cycle_length_reg;
   word_t       cycle_length_buffer_reg;
   logic        cycle_buffer_valid_reg;
   word_t       match_value_reg [3];
   word_t       match_value_buffer_reg [3];
   logic [2:0]  match_buffer_valid_reg;
   logic [2:0]  match_flag_reg;
   logic        wrap_flag_reg;
   logic [2:0]  wave_reg;

   logic        tick;
   word_t       upper_limit;
   logic        at_zero;
   logic        at_upper;
   logic        cycle_end;
   logic        transfer;
   logic [2:0]  match_hit;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function automatic logic wr_hit(input reg_req_s req, input logic [3:0] off);
      wr_hit = req.wr && (req.addr == off);
   endfunction

   // ------------------------------------------------------------
   // prescaler
   // ------------------------------------------------------------
   timer_prescaler u_prescaler (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .run_in    (enable_reg),
      .select_in (prescale_select_reg),
      .tick_out  (tick)
   );

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         enable_reg                <= 1'b0;
         prescale_select_reg       <= 3'h0;
         wave_shape_select_reg     <= WAVE_NORMAL;
         channel_output_enable_reg <= 3'h0;
         count_sense_reg           <= 1'b0;
         lock_transfer_reg         <= 1'b0;
      end else begin
         if (wr_hit(bus_req_in, `OFF_CONTROL_A)) begin
            enable_reg          <= bus_req_in.wdata[`BIT_ENABLE];
            prescale_select_reg <= bus_req_in.wdata[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO]; // [R25]
         end
         if (wr_hit(bus_req_in, `OFF_CONTROL_B)) begin
            // unlisted codes fall back to normal so no pin is driven by accident
            case (bus_req_in.wdata[`BIT_WAVE_HI:`BIT_WAVE_LO])
               2'b01:   wave_shape_select_reg <= WAVE_TONE;
               2'b11:   wave_shape_select_reg <= WAVE_SINGLE;
               default: wave_shape_select_reg <= WAVE_NORMAL;
            endcase
            channel_output_enable_reg <= bus_req_in.wdata[`BIT_CH_EN_HI:`BIT_CH_EN_LO];
         end
         if (wr_hit(bus_req_in, `OFF_CONTROL_E)) begin
            count_sense_reg   <= bus_req_in.wdata[`BIT_COUNT_SENSE]; // [R1]
            lock_transfer_reg <= bus_req_in.wdata[`BIT_LOCK_TRANSFER];
         end
      end
   end

   // ------------------------------------------------------------
   // limits and transfer condition
   // ------------------------------------------------------------
   always_comb begin
      upper_limit = (wave_shape_select_reg == WAVE_TONE) ? match_value_reg[0] : cycle_length_reg; // [R14] [R26]
      at_zero     = (count_value_reg == `ZERO_POINT); // [R24]
      at_upper    = (count_value_reg == upper_limit); // [R9]
      cycle_end   = tick && (count_sense_reg ? at_zero : at_upper);
      transfer    = cycle_end && !lock_transfer_reg; // [R23]
   end

   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count_value_reg <= `RST_COUNT;
      end else if (wr_hit(bus_req_in, `OFF_COUNT)) begin
         count_value_reg <= bus_req_in.wdata; // [R4]
      end else if (tick) begin // [R1]
         if (count_sense_reg) begin
            if (at_zero) begin
               count_value_reg <= upper_limit; // [R3]
            end else begin
               count_value_reg <= count_value_reg - 16'h0001;
            end
         end else begin
            // equality only: a period written below the count rolls through all ones first
            if (at_upper) begin
               count_value_reg <= `ZERO_POINT; // [R2] [R18] [R26]
            end else begin
               count_value_reg <= count_value_reg + 16'h0001;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // period and its buffer
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cycle_length_reg        <= `RST_CYCLE_LENGTH;
         cycle_length_buffer_reg <= `RST_CYCLE_LENGTH;
         cycle_buffer_valid_reg  <= 1'b0;
      end else begin
         if (wr_hit(bus_req_in, `OFF_CYCLE_LENGTH)) begin
            cycle_length_reg <= bus_req_in.wdata; // [R8] [R21] [R22]
         end else if (transfer && cycle_buffer_valid_reg) begin
            cycle_length_reg <= cycle_length_buffer_reg; // [R10]
         end
         if (wr_hit(bus_req_in, `OFF_CYCLE_BUFFER)) begin
            cycle_length_buffer_reg <= bus_req_in.wdata; // [R5]
            cycle_buffer_valid_reg  <= 1'b1; // [R6]
         end else if (transfer) begin
            cycle_buffer_valid_reg  <= 1'b0; // [R6]
         end
      end
   end

   // ------------------------------------------------------------
   // compare channels
   // ------------------------------------------------------------
   for (genvar ch = 0; ch < 3; ch++) begin : g_channel
      localparam logic [3:0] MATCH_OFF = `OFF_MATCH_BASE + 4'(ch);
      localparam logic [3:0] BUF_OFF   = `OFF_MATCH_BUF_BASE + 4'(ch);

      assign match_hit[ch] = tick && (count_value_reg == match_value_reg[ch]); // [R11]

      always_ff @(posedge clk_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            match_value_reg[ch]        <= `RST_MATCH;
            match_value_buffer_reg[ch] <= `RST_MATCH;
            match_buffer_valid_reg[ch] <= 1'b0;
         end else begin
            if (wr_hit(bus_req_in, MATCH_OFF)) begin
               match_value_reg[ch] <= bus_req_in.wdata; // [R7]
            end else if (transfer && match_buffer_valid_reg[ch]) begin
               match_value_reg[ch] <= match_value_buffer_reg[ch]; // [R12]
            end
            if (wr_hit(bus_req_in, BUF_OFF)) begin
               match_value_buffer_reg[ch] <= bus_req_in.wdata; // [R5] [R7]
               match_buffer_valid_reg[ch] <= 1'b1; // [R6]
            end else if (transfer) begin
               match_buffer_valid_reg[ch] <= 1'b0; // [R6]
            end
         end
      end

      // match flag: a new hit beats a clear in the same cycle
      always_ff @(posedge clk_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            match_flag_reg[ch] <= 1'b0;
         end else if (match_hit[ch]) begin
            match_flag_reg[ch] <= 1'b1; // [R11]
         end else if (wr_hit(bus_req_in, `OFF_STATUS) && bus_req_in.wdata[ch]) begin
            match_flag_reg[ch] <= 1'b0;
         end
      end

      always_ff @(posedge clk_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            wave_reg[ch] <= 1'b0;
         end else begin
            case (wave_shape_select_reg)
               WAVE_TONE: begin
                  if (match_hit[ch]) begin
                     wave_reg[ch] <= !wave_reg[ch]; // [R15] [R16] [R17]
                  end
               end
               WAVE_SINGLE: begin
                  // clear checked first so a zero match holds low
                  if (match_hit[ch]) begin
                     wave_reg[ch] <= 1'b0; // [R18] [R19]
                  end else if (tick && at_zero) begin
                     wave_reg[ch] <= 1'b1; // [R18] [R19]
                  end
               end
               default: begin
                  wave_reg[ch] <= 1'b0;
               end
            endcase
         end
      end

      always_ff @(posedge clk_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            wave_pin_out[ch]    <= 1'b0;
            wave_pin_oe_out[ch] <= 1'b0;
         end else begin
            wave_pin_out[ch]    <= wave_reg[ch];
            wave_pin_oe_out[ch] <= (wave_shape_select_reg != WAVE_NORMAL) &&
                                   channel_output_enable_reg[ch] && pin_dir_in[ch]; // [R13]
         end
      end
   end

   // ------------------------------------------------------------
   // wrap flag
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wrap_flag_reg <= 1'b0;
      end else if (cycle_end) begin
         wrap_flag_reg <= 1'b1;
      end else if (wr_hit(bus_req_in, `OFF_STATUS) && bus_req_in.wdata[`BIT_WRAP_FLAG]) begin
         wrap_flag_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_data_out <= 16'h0000;
      end else if (bus_req_in.rd) begin
         case (bus_req_in.addr)
            `OFF_CONTROL_A:      rd_data_out <= {12'h000, prescale_select_reg, enable_reg};
            `OFF_CONTROL_B:      rd_data_out <= {9'h000, channel_output_enable_reg, 2'b00,
                                                 wave_shape_select_reg};
            `OFF_CONTROL_E:      rd_data_out <= {14'h0000, lock_transfer_reg, count_sense_reg};
            `OFF_CONTROL_F:      rd_data_out <= {12'h000, match_buffer_valid_reg, cycle_buffer_valid_reg};
            `OFF_COUNT:          rd_data_out <= count_value_reg;
            `OFF_CYCLE_LENGTH:   rd_data_out <= cycle_length_reg;
            `OFF_CYCLE_BUFFER:   rd_data_out <= cycle_length_buffer_reg;
            `OFF_STATUS:         rd_data_out <= {12'h000, wrap_flag_reg, match_flag_reg};
            4'h8:                rd_data_out <= match_value_reg[0];
            4'h9:                rd_data_out <= match_value_reg[1];
            4'hA:                rd_data_out <= match_value_reg[2];
            4'hC:                rd_data_out <= match_value_buffer_reg[0];
            4'hD:                rd_data_out <= match_value_buffer_reg[1];
            4'hE:                rd_data_out <= match_value_buffer_reg[2];
            default:             rd_data_out <= 16'h0000;
         endcase
      end
   end

endmodule // timer_compare_waveform

`default_nettype wire

// ---- testbench/timer_compare_waveform_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "timer_regs.svh"
// ----------------------------------------
// port-level checker
// ----------------------------------------
module timer_compare_waveform_monitor (
   input wire logic                clk_in,
   input wire logic                arst_n_in,
   input wire timer_pkg::reg_req_s bus_req_in,
   input wire logic [2:0]          pin_dir_in,
   input wire logic [15:0]         rd_data_out,
   input wire logic [2:0]          wave_pin_out,
   input wire logic [2:0]          wave_pin_oe_out
);
   import timer_pkg::*;
   logic       normal_reg;
   logic [2:0] ch_en_reg;
   logic [2:0] oe_next;
   reg_req_s   q;
   assign q = bus_req_in;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   // shadow of mode and channel enables, seen only from bus writes
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         normal_reg <= 1'b1;
         ch_en_reg  <= 3'h0;
      end else if (q.wr && q.addr == `OFF_CONTROL_B) begin
         normal_reg <= ~q.wdata[0];
         ch_en_reg  <= q.wdata[6:4];
      end
   end
   assign oe_next = {3{~normal_reg}} & ch_en_reg & pin_dir_in;
   a_pin_drive_gate: assert property (
      wave_pin_oe_out == $past(oe_next)) else $error("pin enable wrong");
   a_count_write_wins: assert property (
      (q.wr && q.addr == `OFF_COUNT) ##1 (q.rd && q.addr == `OFF_COUNT)
      |=> rd_data_out == $past(q.wdata, 2)) else $error("count write not immediate");
   a_period_direct_now: assert property (
      (q.wr && q.addr == `OFF_CYCLE_LENGTH) ##1 (q.rd && q.addr == `OFF_CYCLE_LENGTH)
      |=> rd_data_out == $past(q.wdata, 2)) else $error("period write not immediate");
   a_match_direct_path: assert property (
      (q.wr && q.addr inside {4'h8, 4'h9, 4'hA}) ##1 (q.rd && q.addr == $past(q.addr))
      |=> rd_data_out == $past(q.wdata, 2)) else $error("match write lost");
   a_cycle_buf_hold: assert property (
      (q.wr && q.addr == `OFF_CYCLE_BUFFER) ##1 (q.rd && q.addr == `OFF_CYCLE_BUFFER)
      |=> rd_data_out == $past(q.wdata, 2)) else $error("period buffer lost");
   a_match_buf_hold: assert property (
      (q.wr && q.addr inside {4'hC, 4'hD, 4'hE}) ##1 (q.rd && q.addr == $past(q.addr))
      |=> rd_data_out == $past(q.wdata, 2)) else $error("match buffer lost");
   a_cycle_valid_set: assert property (
      (q.wr && q.addr == `OFF_CYCLE_BUFFER) ##1 (q.rd && q.addr == `OFF_CONTROL_F)
      |=> rd_data_out[0]) else $error("period valid flag not set");
   a_match_valid_set: assert property (
      (q.wr && q.addr == `OFF_MATCH_BUF_BASE) ##1 (q.rd && q.addr == `OFF_CONTROL_F)
      |=> rd_data_out[1]) else $error("match valid flag not set");
endmodule // timer_compare_waveform_monitor

bind timer_compare_waveform timer_compare_waveform_monitor timer_compare_waveform_monitor_i (
   .clk_in(clk_in), .arst_n_in(arst_n_in), .bus_req_in(bus_req_in), .pin_dir_in(pin_dir_in),
   .rd_data_out(rd_data_out), .wave_pin_out(wave_pin_out), .wave_pin_oe_out(wave_pin_oe_out));
`default_nettype wire

// ---- testbench/pin_port_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// port pins with pull-ups
// ----------------------------------------
module pin_port_model (
   input  wire logic [2:0] dir_set_in,
   input  wire logic [2:0] wave_in,
   input  wire logic [2:0] oe_in,
   output logic      [2:0] pin_dir_out,
   output logic      [2:0] pin_level_out
);
   assign pin_dir_out   = dir_set_in;
   // an undriven pin floats to the pull-up, not the last wave value
   assign pin_level_out = (oe_in & wave_in) | ~oe_in;
endmodule // pin_port_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "timer_regs.svh"
module tb_top;
   import timer_pkg::*;
   logic        clk_in;
   logic        arst_n_in;
   reg_req_s    req;
   logic [2:0]  dir_set;
   logic [2:0]  pin_dir;
   logic [15:0] rd_data;
   logic [2:0]  wave;
   logic [2:0]  oe;
   logic [2:0]  pin;
   int          fails;
   int          checks_done;
   timer_compare_waveform timer_compare_waveform_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .bus_req_in(req), .pin_dir_in(pin_dir), .rd_data_out(rd_data), .wave_pin_out(wave),
      .wave_pin_oe_out(oe));
   pin_port_model pin_port_model_i (.dir_set_in(dir_set), .wave_in(wave), .oe_in(oe),
      .pin_dir_out(pin_dir), .pin_level_out(pin));
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   // ----------------------------------------
   // bus and judging helpers
   // ----------------------------------------
   task automatic check(input word_t seen, input word_t exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic op(input logic w, input logic r, input logic [3:0] a, input word_t d);
      @(posedge clk_in);
      req <= '{addr: a, wdata: d, wr: w, rd: r};
   endtask
   task automatic wr(input logic [3:0] a, input word_t d);
      op(1'b1, 1'b0, a, d);
      op(1'b0, 1'b0, 4'h0, 16'h0000);
   endtask
   task automatic rd(input logic [3:0] a, input word_t exp);
      op(1'b0, 1'b1, a, 16'h0000);
      op(1'b0, 1'b0, 4'h0, 16'h0000);
      #1 check(rd_data, exp);
   endtask
   // write then read in the very next cycle
   task automatic wrrd(input logic [3:0] wa, input word_t d, input logic [3:0] ra, input word_t exp);
      op(1'b1, 1'b0, wa, d);
      rd(ra, exp);
   endtask
   task automatic cfg(input logic [1:0] mode, input logic [2:0] dsel, input word_t per, input word_t m [3]);
      wr(`OFF_CONTROL_A, 16'h0000);
      wr(`OFF_CYCLE_LENGTH, per);
      wr(`OFF_CYCLE_BUFFER, per);
      for (int i = 0; i < 3; i++) begin
         wr(`OFF_MATCH_BASE + 4'(i), m[i]);
         wr(`OFF_MATCH_BUF_BASE + 4'(i), m[i]);
      end
      wr(`OFF_COUNT, 16'h0000);
      wr(`OFF_CONTROL_B, {9'h000, 3'h7, 2'h0, mode});
      wr(`OFF_CONTROL_A, {12'h000, dsel, 1'b1});
   endtask
   // one full pin period from rising edge to rising edge
   task automatic measure(input int ch, input int per, input int hi);
      int   k;
      int   t;
      int   h;
      logic p;
      k = 0;
      t = 0;
      h = 0;
      p = 1'b1;
      while (pin[ch] !== 1'b0 && k < 5000) begin @(negedge clk_in); k++; end
      while (pin[ch] !== 1'b1 && k < 5000) begin @(negedge clk_in); k++; end
      while (!(p === 1'b0 && pin[ch] === 1'b1) && t < 5000) begin
         h += (pin[ch] === 1'b1);
         p = pin[ch];
         t++;
         @(negedge clk_in);
      end
      if (k >= 5000 || t >= 5000) begin
         fails++;
         print_verdict;
      end
      check(word_t'(t), word_t'(per));
      check(word_t'(h), word_t'(hi));
   endtask
   task automatic steady(input int ch, input logic lvl);
      int n;
      n = 0;
      repeat (40) begin @(negedge clk_in); n += (pin[ch] === lvl); end
      check(word_t'(n), 16'h0028);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic reset_values;
      rd(`OFF_COUNT, 16'h0000);
      rd(`OFF_CYCLE_LENGTH, 16'hFFFF);
      rd(`OFF_CYCLE_BUFFER, 16'hFFFF);
      rd(`OFF_CONTROL_F, 16'h0000);
      for (int i = 0; i < 3; i++) rd(`OFF_MATCH_BUF_BASE + 4'(i), 16'h0000);
      rd(4'hB, 16'h0000);
   endtask
   task automatic access_paths;
      wrrd(4'h4, 16'h1234, 4'h4, 16'h1234);
      wrrd(4'h5, 16'h00FF, 4'h5, 16'h00FF);
      wrrd(4'h6, 16'h0AAA, 4'h6, 16'h0AAA);
      wrrd(4'h6, 16'h0BBB, 4'h3, 16'h0001);
      wrrd(4'hC, 16'h0005, 4'h3, 16'h0003);
      wrrd(4'hD, 16'h0006, 4'hD, 16'h0006);
      wrrd(4'hE, 16'h0007, 4'h3, 16'h000F);
      for (int i = 0; i < 3; i++) wrrd(4'h8 + 4'(i), 16'h0011, 4'h8 + 4'(i), 16'h0011);
   endtask
   // back-to-back count reads, one tick apart at divisor 1
   task automatic count_run(input logic down, input word_t per, input word_t start);
      word_t c;
      c = start;
      wr(`OFF_CONTROL_E, {15'h0000, down});
      wr(`OFF_CYCLE_LENGTH, per);
      wr(`OFF_CYCLE_BUFFER, per);
      op(1'b1, 1'b0, `OFF_COUNT, start);
      for (int i = 0; i < 7; i++) begin
         op(1'b0, 1'b1, `OFF_COUNT, 16'h0000);
         #1;
         if (i > 0) begin
            check(rd_data, c);
            if (down) c = (c == 16'h0000) ? per : c - 16'h0001;
            else c = (c == per) ? 16'h0000 : c + 16'h0001;
         end
      end
      op(1'b0, 1'b0, 4'h0, 16'h0000);
   endtask
   task automatic counting;
      wr(`OFF_CONTROL_B, 16'h0000);
      wr(`OFF_CONTROL_A, 16'h0001);
      count_run(1'b0, 16'h0005, 16'h0003);
      count_run(1'b1, 16'h0009, 16'h0002);
      count_run(1'b0, 16'h0003, 16'h0008);
      #1 check({13'h0000, oe}, 16'h0000);
      wr(`OFF_CONTROL_A, 16'h0000);
      rd(`OFF_STATUS, 16'h000F);
      wr(`OFF_STATUS, 16'h000F);
      rd(`OFF_STATUS, 16'h0000);
   endtask
   task automatic pwm;
      // count sense left at up: down counting is not allowed in single slope
      rd(`OFF_CONTROL_E, 16'h0000);
      cfg(WAVE_SINGLE, 3'h0, 16'h0003, '{16'h0001, 16'h0000, 16'h0004});
      measure(0, 4, 1);
      steady(1, 1'b0);
      steady(2, 1'b1);
      cfg(WAVE_SINGLE, 3'h2, 16'h0005, '{16'h0002, 16'h0000, 16'h0000});
      measure(0, 24, 8);
   endtask
   task automatic buffered;
      cfg(WAVE_SINGLE, 3'h0, 16'h0007, '{16'h0002, 16'h0000, 16'h0000});
      repeat (20) @(posedge clk_in);
      wr(`OFF_CONTROL_E, 16'h0002);
      wr(`OFF_CYCLE_BUFFER, 16'h0003);
      repeat (30) @(posedge clk_in);
      rd(`OFF_CONTROL_F, 16'h0001);
      rd(`OFF_CYCLE_LENGTH, 16'h0007);
      wr(`OFF_CONTROL_E, 16'h0000);
      repeat (20) @(posedge clk_in);
      rd(`OFF_CONTROL_F, 16'h0000);
      rd(`OFF_CYCLE_LENGTH, 16'h0003);
      measure(0, 4, 2);
      wr(`OFF_MATCH_BUF_BASE, 16'h0001);
      repeat (20) @(posedge clk_in);
      rd(`OFF_MATCH_BASE, 16'h0001);
      measure(0, 4, 1);
   endtask
   task automatic tone;
      cfg(WAVE_TONE, 3'h0, 16'hFFFF, '{16'h0000, 16'h0000, 16'h0000});
      measure(0, 2, 1);
      cfg(WAVE_TONE, 3'h1, 16'hFFFF, '{16'h0003, 16'h0001, 16'h0002});
      measure(0, 16, 8);
      measure(1, 16, 8);
      @(posedge clk_in);
      dir_set <= 3'b011;
      repeat (3) @(posedge clk_in);
      #1 check({13'h0000, oe}, 16'h0003);
      check({15'h0000, pin[2]}, 16'h0001);
      @(posedge clk_in);
      dir_set <= 3'b111;
   endtask
   initial begin
      req         = '0;
      dir_set     = 3'b111;
      arst_n_in   = 1'b0;
      fails       = 0;
      checks_done = 0;
      repeat (16) @(posedge clk_in);
      arst_n_in <= 1'b1;
      reset_values;
      access_paths;
      counting;
      pwm;
      buffered;
      tone;
      print_verdict;
   end
   // hang guard well over the cycle budget
   initial begin
      #4000000;
      fails++;
      print_verdict;
   end
endmodule // tb_top
`default_nettype wire
